// ### rtl/status_alert_pkg.sv
// constants for the status latch and alert block
package status_alert_pkg;
   // ************************************************
   // register map
   // ************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int GRP_W = 8;
   localparam int NUM_GRP = 4;
   localparam logic [ADDR_W-1:0] ADDR_STAT_VOUT = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STAT_IOUT = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_STAT_TEMP = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STAT_CML = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_MASK_BASE = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_SUM_BYTE = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_SUM_WORD = 4'h9;
   // ************************************************
   // reset values
   // ************************************************
   localparam logic [GRP_W-1:0] MASK_RST = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
   localparam logic [DATA_W-1:0] UNMAPPED_RD = 16'h0000;
   // ************************************************
   // summary word bit positions
   // ************************************************
   localparam int SUM_CML = 1;
   localparam int SUM_TEMP = 2;
   localparam int SUM_IOUT_OC = 4;
   localparam int SUM_VOUT_OV = 5;
   localparam int SUM_OFF = 6;
   localparam int SUM_PGOOD_N = 11;
   localparam int SUM_IOUT = 14;
   localparam int SUM_VOUT = 15;
   localparam int GRP_FAULT_BIT = 7;
   localparam int GRP_VOUT = 0;
   localparam int GRP_IOUT = 1;
   localparam int GRP_TEMP = 2;
   localparam int GRP_CML = 3;
   localparam int PIN_SYNC_STAGES = 3;
endpackage

// ### rtl/latch_if.sv
// carrier between the alert logic and its latch bank
`timescale 1ns/1ps
interface latch_if #(parameter int W = 32) ();
   logic [W-1:0] evt;
   logic [W-1:0] clr;
   logic [W-1:0] latch;
   logic [W-1:0] req;
   modport bank (input evt, input clr, output latch, output req);
   modport ctrl (output evt, output clr, input latch, input req);
endinterface

// ### rtl/status_latch_bank.sv
// bank of set-dominant event latches
`timescale 1ns/1ps
module status_latch_bank #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst,
   latch_if.bank lif
);
   logic [W-1:0] latch_reg;
   logic [W-1:0] latch_next;

   if (W < 1) begin : width_check
      $error("latch bank width must be at least one");
   end

   // clear is only a pulse; a live detector wins and re-sets at once
   always_comb begin
      latch_next = (latch_reg & ~lif.clr) | lif.evt; // RL6 RL12 RL4
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_reg <= '0;
      end else begin
         latch_reg <= latch_next;
      end
   end

   assign lif.latch = latch_reg;
   // new set, or a clear that the live condition defeats
   assign lif.req = lif.evt & (~latch_reg | lif.clr); // RL5 RL8

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   set_wins_a: assert property ( // RL12
      (|lif.evt) |=> ((lif.latch & $past(lif.evt)) == $past(lif.evt)))
      else $error("live event did not hold its latch set");
   sticky_hold_a: assert property ( // RL13
      (|(lif.latch & ~lif.clr)) |=>
      ((lif.latch & $past(lif.latch & ~lif.clr)) == $past(lif.latch & ~lif.clr)))
      else $error("latched bit dropped without a clear");
   clear_drop_a: assert property ( // RL11
      (|(lif.clr & lif.latch & ~lif.evt)) |=>
      ((lif.latch & $past(lif.clr & ~lif.evt)) == '0))
      else $error("cleared latch stayed set");
endmodule

// ### rtl/status_alert_top.sv
// status latches, summary bits and the shared alert output
//
// Notes on behaviour
// RL1 - each of the VOUT, IOUT, TEMP and CML summary bits is the OR of its group of latches
// RL2 - summary bit falls with the last contributing latch, same cycle
// RL3 - off and power-good-negated bits follow live state, never latched
// RL4 - clearing a bit whose condition persists sets it again at once
// RL5 - such a clear re-raises the alert unless that bit is masked
// RL6 - each detected event sets its own latch, seen as a status bit
// RL7 - a set mask bit keeps its latch away from the alert
// RL8 - a rising unmasked latch drives the alert output low
// RL9 - alert holds low until cleared; a successful alert reply releases it
// RL10 - a clear-faults command releases the alert
// RL11 - writing a one to a status bit resets the latch behind it
// RL12 - clears are pulses; a live detector re-sets the latch immediately
// RL13 - latches stay set until cleared, clear-faults or off-then-on
// RL14 - status write clears bits at one positions only; summaries excluded
// RL15 - all unmasked latch edges merge into one alert request
// RL16 - reads return latches without clearing them or touching the alert
`timescale 1ns/1ps
module status_alert_top #(
   parameter int NUM_GRP = status_alert_pkg::NUM_GRP
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   // register port
   input wire logic [status_alert_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [status_alert_pkg::DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [status_alert_pkg::DATA_W-1:0] REG_RDATA_OUT,
   // event detectors and device state
   input wire logic [NUM_GRP*status_alert_pkg::GRP_W-1:0] EVENT_IN,
   input wire logic OUTPUT_ON_IN,
   input wire logic PGOOD_PIN_IN,
   // bus engine pulses
   input wire logic CLEAR_FAULTS_IN,
   input wire logic ARA_DONE_IN,
   // open-drain alert pin
   output logic ALERT_N_OUT,
   output logic ALERT_N_OE_OUT
);
   localparam int GW = status_alert_pkg::GRP_W;
   localparam int LW = NUM_GRP * GW;
   localparam int SN = status_alert_pkg::PIN_SYNC_STAGES;

   // the summary and read wiring are fixed to the default group count
   if (NUM_GRP != status_alert_pkg::NUM_GRP) begin : grp_count_check
      $error("summary wiring serves only the default group count");
   end

   // ************************************************
   // address decoding
   // ************************************************
   function automatic logic is_stat(input logic [status_alert_pkg::ADDR_W-1:0] a);
      is_stat = (a < status_alert_pkg::ADDR_MASK_BASE);
   endfunction

   function automatic logic is_mask(input logic [status_alert_pkg::ADDR_W-1:0] a);
      is_mask = (a >= status_alert_pkg::ADDR_MASK_BASE) &&
         (a < status_alert_pkg::ADDR_SUM_BYTE);
   endfunction

   // ************************************************
   // power-good synchroniser and on-state edge
   // ************************************************
   logic [SN-1:0] pg_sync_reg;
   logic [SN-1:0] pg_sync_next;
   logic pgood_reg;
   logic pgood_next;
   logic on_prev_reg;
   logic on_prev_next;
   logic on_rise;

   always_comb begin
      pg_sync_next = {pg_sync_reg[SN-2:0], PGOOD_PIN_IN};
      pgood_next = pgood_reg;
      // only a level seen by the last two stages alike is taken
      if (pg_sync_reg[SN-1] == pg_sync_reg[SN-2]) begin
         pgood_next = pg_sync_reg[SN-1];
      end
      on_prev_next = OUTPUT_ON_IN;
   end

   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         pg_sync_reg <= '0;
         pgood_reg <= 1'b0;
         on_prev_reg <= 1'b0;
      end else begin
         pg_sync_reg <= pg_sync_next;
         pgood_reg <= pgood_next;
         on_prev_reg <= on_prev_next;
      end
   end

   // output turned back on after being off
   assign on_rise = OUTPUT_ON_IN & ~on_prev_reg; // RL13

   // ************************************************
   // latch bank and clear pulses
   // ************************************************
   latch_if #(.W(LW)) lif ();
   logic clear_all;
   logic [LW-1:0] mask_flat;
   logic [LW-1:0] gated_req;

   assign clear_all = CLEAR_FAULTS_IN | on_rise; // RL13 RL10
   assign lif.evt = EVENT_IN; // RL6

   genvar g;
   generate
      for (g = 0; g < NUM_GRP; g++) begin : grp
         logic hit;
         assign hit = REG_WR_IN && is_stat(REG_ADDR_IN) &&
            (REG_ADDR_IN == status_alert_pkg::ADDR_W'(g));
         // one positions clear, zero positions stay; summaries never hit
         assign lif.clr[g*GW +: GW] = clear_all ? {GW{1'b1}} :
            (hit ? REG_WDATA_IN[GW-1:0] : {GW{1'b0}}); // RL11 RL14
      end
   endgenerate

   status_latch_bank #(.W(LW)) bank (
      .clk(CLK_IN),
      .rst(SYS_RST_IN),
      .lif(lif)
   );

   // ************************************************
   // alert mask registers
   // ************************************************
   logic [GW-1:0] mask_reg [NUM_GRP];
   logic [GW-1:0] mask_next [NUM_GRP];

   always_comb begin
      for (int i = 0; i < NUM_GRP; i++) begin
         mask_next[i] = mask_reg[i];
         if (REG_WR_IN && is_mask(REG_ADDR_IN) &&
            (REG_ADDR_IN == status_alert_pkg::ADDR_W'(i) + status_alert_pkg::ADDR_MASK_BASE)) begin
            mask_next[i] = REG_WDATA_IN[GW-1:0];
         end
      end
   end

   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         for (int i = 0; i < NUM_GRP; i++) begin
            mask_reg[i] <= status_alert_pkg::MASK_RST;
         end
      end else begin
         mask_reg <= mask_next;
      end
   end

   generate
      for (g = 0; g < NUM_GRP; g++) begin : mflat
         assign mask_flat[g*GW +: GW] = mask_reg[g];
      end
   endgenerate

   assign gated_req = lif.req & ~mask_flat; // RL7

   // ************************************************
   // alert latch
   // ************************************************
   logic alert_reg;
   logic alert_next;
   logic alert_set;

   assign alert_set = |gated_req; // RL15

   always_comb begin
      alert_next = alert_reg;
      // a fresh edge in the releasing cycle keeps the pin low
      if (alert_set) begin
         alert_next = 1'b1; // RL8 RL5
      end else if (ARA_DONE_IN || CLEAR_FAULTS_IN) begin
         alert_next = 1'b0; // RL9 RL10
      end
   end

   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= alert_next;
      end
   end

   // open drain: drive low only while asserted
   assign ALERT_N_OUT = 1'b0;
   assign ALERT_N_OE_OUT = alert_reg;

   // ************************************************
   // summary bits
   // ************************************************
   logic [status_alert_pkg::DATA_W-1:0] sum_word;
   logic [GW-1:0] grp_v;
   logic [GW-1:0] grp_i;
   logic [GW-1:0] grp_t;
   logic [GW-1:0] grp_c;

   assign grp_v = lif.latch[status_alert_pkg::GRP_VOUT*GW +: GW];
   assign grp_i = lif.latch[status_alert_pkg::GRP_IOUT*GW +: GW];
   assign grp_t = lif.latch[status_alert_pkg::GRP_TEMP*GW +: GW];
   assign grp_c = lif.latch[status_alert_pkg::GRP_CML*GW +: GW];

   // pure OR of live latches, so bits fall with the last one; off and power-good bits are live state
   always_comb begin
      sum_word = '0;
      sum_word[status_alert_pkg::SUM_CML] = |grp_c; // RL1 RL2
      sum_word[status_alert_pkg::SUM_TEMP] = |grp_t; // RL1
      sum_word[status_alert_pkg::SUM_IOUT_OC] = grp_i[status_alert_pkg::GRP_FAULT_BIT];
      sum_word[status_alert_pkg::SUM_VOUT_OV] = grp_v[status_alert_pkg::GRP_FAULT_BIT];
      sum_word[status_alert_pkg::SUM_OFF] = ~OUTPUT_ON_IN; // RL3
      sum_word[status_alert_pkg::SUM_PGOOD_N] = ~pgood_reg; // RL3
      sum_word[status_alert_pkg::SUM_IOUT] = |grp_i; // RL1
      sum_word[status_alert_pkg::SUM_VOUT] = |grp_v; // RL1 RL2
   end

   // ************************************************
   // read port
   // ************************************************
   logic [status_alert_pkg::DATA_W-1:0] rdata_reg;
   logic [status_alert_pkg::DATA_W-1:0] rdata_next;

   // reads only select; no latch or alert state moves on a read
   always_comb begin
      rdata_next = rdata_reg;
      if (REG_RD_IN) begin
         if (is_stat(REG_ADDR_IN)) begin
            rdata_next = {{(status_alert_pkg::DATA_W-GW){1'b0}},
               lif.latch[REG_ADDR_IN[1:0]*GW +: GW]}; // RL16
         end else if (is_mask(REG_ADDR_IN)) begin
            rdata_next = {{(status_alert_pkg::DATA_W-GW){1'b0}},
               mask_reg[REG_ADDR_IN[1:0]]};
         end else if (REG_ADDR_IN == status_alert_pkg::ADDR_SUM_BYTE) begin
            rdata_next = {{(status_alert_pkg::DATA_W-GW){1'b0}}, sum_word[GW-1:0]};
         end else if (REG_ADDR_IN == status_alert_pkg::ADDR_SUM_WORD) begin
            rdata_next = sum_word;
         end else begin
            rdata_next = status_alert_pkg::UNMAPPED_RD;
         end
      end
   end

   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         rdata_reg <= status_alert_pkg::RDATA_RST;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign REG_RDATA_OUT = rdata_reg;

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   sequence vout_clear_s;
      REG_WR_IN && (REG_ADDR_IN == status_alert_pkg::ADDR_STAT_VOUT);
   endsequence

   sequence stat_read_s;
      REG_RD_IN && is_stat(REG_ADDR_IN);
   endsequence

   alert_rise_a: assert property ( // RL8
      alert_set |=> (ALERT_N_OE_OUT && !ALERT_N_OUT))
      else $error("unmasked edge did not pull the alert low");
   ara_release_a: assert property ( // RL9
      (ARA_DONE_IN && !alert_set) |=> !ALERT_N_OE_OUT)
      else $error("alert reply did not release the alert");
   cf_release_a: assert property ( // RL10
      (CLEAR_FAULTS_IN && !alert_set) |=> !ALERT_N_OE_OUT)
      else $error("clear faults did not release the alert");
   alert_hold_a: assert property ( // RL9
      (ALERT_N_OE_OUT && !ARA_DONE_IN && !CLEAR_FAULTS_IN) |=> ALERT_N_OE_OUT)
      else $error("alert released without a clear");
   mask_block_a: assert property ( // RL7
      (!ALERT_N_OE_OUT && ((lif.req & ~mask_flat) == '0)) |=> !ALERT_N_OE_OUT)
      else $error("masked latch reached the alert");
   reassert_a: assert property ( // RL5
      (vout_clear_s and ((REG_WDATA_IN[GW-1:0] & EVENT_IN[GW-1:0] &
         ~mask_reg[0]) != '0)) |=> ALERT_N_OE_OUT)
      else $error("clear of live condition did not re-raise the alert");
   w1c_clear_a: assert property ( // RL14
      (vout_clear_s and !CLEAR_FAULTS_IN) |=>
      ((grp_v & $past(REG_WDATA_IN[GW-1:0] & ~EVENT_IN[GW-1:0])) == '0))
      else $error("status write left a selected bit set");
   summary_or_a: assert property ( // RL1
      (sum_word[status_alert_pkg::SUM_VOUT] == (grp_v != '0)) &&
      (sum_word[status_alert_pkg::SUM_IOUT] == (grp_i != '0)))
      else $error("summary bit differs from OR of its group");
   off_live_a: assert property ( // RL3
      sum_word[status_alert_pkg::SUM_OFF] == !OUTPUT_ON_IN)
      else $error("off bit does not follow live output state");
   read_quiet_a: assert property ( // RL16
      (stat_read_s and !REG_WR_IN && !clear_all && (EVENT_IN == '0) &&
         !ARA_DONE_IN) |=>
      ((lif.latch == $past(lif.latch)) && (ALERT_N_OE_OUT == $past(ALERT_N_OE_OUT))))
      else $error("read changed latch or alert state");
   read_data_a: assert property ( // RL16
      (stat_read_s and (REG_ADDR_IN == status_alert_pkg::ADDR_STAT_VOUT)) |=>
      (REG_RDATA_OUT[GW-1:0] == $past(grp_v)))
      else $error("status read returned wrong data");
endmodule

// ### tb/alert_host_model.sv
// host-side model: pulled-up alert wire and alert response servicing
`timescale 1ns/1ps
module alert_host_model (
   // clock
   input wire logic clk_in,
   // alert pin from the device
   input wire logic alert_n_in,
   input wire logic alert_oe_in,
   // servicing control
   input wire logic ara_en_in,
   input wire logic [3:0] ara_dly_in,
   output logic ara_done_out,
   output logic alert_wire_out
);
   logic [3:0] cnt;
   logic sent;
   // pull-up holds the wire high whenever nobody drives it
   assign alert_wire_out = alert_oe_in ? alert_n_in : 1'b1;
   initial begin
      ara_done_out = 1'b0;
      cnt = 4'h0;
      sent = 1'b0;
   end
   // one reply per request; a slow host waits ara_dly_in cycles first
   always @(posedge clk_in) begin
      ara_done_out <= 1'b0;
      if (!ara_en_in) begin
         cnt <= 4'h0;
         sent <= 1'b0;
      end else if (!alert_wire_out && !sent) begin
         if (cnt == ara_dly_in) begin
            ara_done_out <= 1'b1;
            sent <= 1'b1;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// ### tb/status_alert_top_bench.sv
// self-checking bench for the status latch and alert block
`timescale 1ns/1ps
module status_alert_top_bench;
   logic clk, rst, wr, rd, on, pg, cf, ara_en, ara_done, oe, an, wire_n;
   logic [3:0] addr, ara_dly;
   logic [15:0] wdata, rdata;
   logic [31:0] evt;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   status_alert_top dut (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .EVENT_IN(evt), .OUTPUT_ON_IN(on), .PGOOD_PIN_IN(pg), .CLEAR_FAULTS_IN(cf),
      .ARA_DONE_IN(ara_done), .ALERT_N_OUT(an), .ALERT_N_OE_OUT(oe));
   alert_host_model host (.clk_in(clk), .alert_n_in(an), .alert_oe_in(oe),
      .ara_en_in(ara_en), .ara_dly_in(ara_dly), .ara_done_out(ara_done),
      .alert_wire_out(wire_n));
   // ************************************************
   // clock, timeout and verdict
   // ************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic print_verdict();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         print_verdict();
      end
   end
   // ************************************************
   // access tasks
   // ************************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk($sformatf("reg%0d", a), exp, rdata);
   endtask
   // pin low and enable high together mean asserted
   task automatic alert(input logic exp);
      @(posedge clk);
      #1 chk("alert", exp ? 16'h0001 : 16'h0002, {14'h0000, wire_n, oe});
   endtask
   task automatic pulse_evt(input logic [31:0] b);
      @(posedge clk);
      evt <= b;
      @(posedge clk);
      evt <= 32'h0000_0000;
   endtask
   task automatic ara(input logic [3:0] d);
      int n = 0;
      @(posedge clk);
      ara_dly <= d;
      ara_en <= 1'b1;
      while (ara_done !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      ara_en <= 1'b0;
      chk("ara_done", 16'h0001, {15'h0000, ara_done});
   endtask
   task automatic clear_faults();
      @(posedge clk);
      cf <= 1'b1;
      @(posedge clk);
      cf <= 1'b0;
   endtask
   // ************************************************
   // tests
   // ************************************************
   initial begin
      {wr, rd, cf, ara_en, addr, ara_dly, wdata, evt} = '0;
      on = 1'b1;
      pg = 1'b1;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 0; i < 8; i++) rreg(i[3:0], 16'h0000);
      rreg(4'h9, 16'h0000);
      rreg(4'hC, 16'h0000);
      alert(1'b0);
      // single fault: latched, summarised, alert raised
      pulse_evt(32'h0000_0080);
      alert(1'b1);
      rreg(4'h0, 16'h0080);
      rreg(4'h9, 16'h8020);
      rreg(4'h8, 16'h0020);
      alert(1'b1);
      ara(4'h0);
      alert(1'b0);
      rreg(4'h0, 16'h0080);
      wreg(4'h0, 16'h0001);
      rreg(4'h0, 16'h0080);
      wreg(4'h0, 16'h0080);
      rreg(4'h9, 16'h0000);
      alert(1'b0);
      // live condition survives a clear and re-raises the alert
      @(posedge clk);
      evt <= 32'h0000_0800;
      alert(1'b1);
      ara(4'h5);
      alert(1'b0);
      wreg(4'h1, 16'h0008);
      rreg(4'h1, 16'h0008);
      alert(1'b1);
      @(posedge clk);
      evt <= 32'h0000_0000;
      clear_faults();
      alert(1'b0);
      rreg(4'h1, 16'h0000);
      // masked group latches but stays off the alert
      wreg(4'h6, 16'h00FF);
      rreg(4'h6, 16'h00FF);
      pulse_evt(32'h0001_0000);
      alert(1'b0);
      rreg(4'h2, 16'h0001);
      rreg(4'h9, 16'h0004);
      @(posedge clk);
      evt <= 32'h0001_0000;
      wreg(4'h2, 16'h0001);
      alert(1'b0);
      @(posedge clk);
      evt <= 32'h0000_0000;
      wreg(4'h2, 16'h0001);
      rreg(4'h2, 16'h0000);
      wreg(4'h6, 16'h0000);
      // two groups at once share one alert
      pulse_evt(32'h0400_0002);
      alert(1'b1);
      rreg(4'h9, 16'h8002);
      wreg(4'h0, 16'h0002);
      rreg(4'h9, 16'h0002);
      ara(4'h2);
      alert(1'b0);
      wreg(4'h3, 16'h0004);
      rreg(4'h9, 16'h0000);
      // live off and power-good bits; off-then-on clears latches
      pulse_evt(32'h0000_8001);
      @(posedge clk);
      on <= 1'b0;
      rreg(4'h9, 16'hC050);
      @(posedge clk);
      on <= 1'b1;
      rreg(4'h9, 16'h0000);
      @(posedge clk);
      pg <= 1'b0;
      repeat (8) @(posedge clk);
      clear_faults();
      wreg(4'h9, 16'hFFFF);
      rreg(4'h9, 16'h0800);
      @(posedge clk);
      pg <= 1'b1;
      repeat (8) @(posedge clk);
      rreg(4'h9, 16'h0000);
      print_verdict();
   end
endmodule
